/* File: hw/mgmt_pkg.sv */
// shared constants for the module management link: memory map, timing, host command registers
// assumes a 10 MHz system clock on both ends
package mgmt_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_RESET_INIT_NS = 10000;
  localparam int T_SEL_ASSERT_NS = 2000;
  localparam int T_SEL_DEASSERT_NS = 2000;
  localparam logic [7:0] RESET_MIN_CNT = 8'((T_RESET_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SEL_ASSERT_CNT = 8'((T_SEL_ASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SEL_DEASSERT_CNT = 8'((T_SEL_DEASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] SCL_QUARTER_CNT = 3'h3;
  // two-wire addressing
  localparam logic [6:0] DEV_ADDR = 7'h50;
  // management memory
  localparam int PAGE_BYTES = 128;
  localparam int MEM_BYTES = 768;
  localparam logic [7:0] STATUS_OFS = 8'h03;
  localparam logic [7:0] FLAGS_OFS = 8'h08;
  localparam logic [7:0] CTRL_OFS = 8'h1A;
  localparam logic [7:0] BANK_OFS = 8'h7E;
  localparam logic [7:0] PAGE_OFS = 8'h7F;
  localparam logic [7:0] PAGE_00 = 8'h00;
  localparam logic [7:0] PAGE_01 = 8'h01;
  localparam logic [7:0] PAGE_02 = 8'h02;
  localparam logic [7:0] PAGE_10 = 8'h10;
  localparam logic [7:0] PAGE_11 = 8'h11;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int CTRL_FORCE_LP = 0;
  localparam int FLG_LP_CHG = 0;
  localparam int FLG_BAD_PAGE = 1;
  localparam int FLG_RESET_DONE = 2;
  localparam int FLG_FAULT = 3;
  // host APB registers
  localparam logic [11:0] A_PINS = 12'h000;
  localparam logic [11:0] A_CMD = 12'h004;
  localparam logic [11:0] A_STAT = 12'h008;
  localparam logic [2:0] PINS_RST = 3'h4;
  localparam int PIN_SEL = 0;
  localparam int PIN_RESET = 1;
  localparam int PIN_LP = 2;
  localparam int CMD_READ = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
  localparam int ST_ATTN = 2;
  localparam int ST_PRESENT = 3;
endpackage

/* File: hw/mgmt_link_if.sv */
// pins between host controller and module: two-wire bus and sideband lines
// open-drain lines resolve to high through the host pull-ups
interface mgmt_link_if;
  logic scl;
  logic sda;
  logic sda_h_o;
  logic sda_h_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  logic module_select_n;
  logic module_reset_n;
  logic low_power_request_pin;
  logic present_o;
  logic present_oe_n;
  logic module_present_n;
  logic attn_o;
  logic attn_oe_n;
  logic attention_n;
  assign sda = ~((~sda_h_oe_n & ~sda_h_o) | (~sda_d_oe_n & ~sda_d_o));
  assign module_present_n = present_oe_n ? 1'b1 : present_o;
  assign attention_n = attn_oe_n ? 1'b1 : attn_o;
  modport dev (
    input scl, sda, module_select_n, module_reset_n, low_power_request_pin,
    output sda_d_o, sda_d_oe_n, present_o, present_oe_n, attn_o, attn_oe_n
  );
  modport host (
    output scl, sda_h_o, sda_h_oe_n, module_select_n, module_reset_n, low_power_request_pin,
    input sda, module_present_n, attention_n
  );
endinterface

/* File: hw/mgmt_module.sv */
// module end: two-wire slave, select gating, reset filter, paged management memory, attention line
// assumes all link pins are asynchronous to I_CLK; the host makes SCL slow enough for the synchronisers
// What the document says about the link
// - answer the bus only while selected low
// - deselected: no acknowledge, no response at all
// - host waits deassert time after deselecting
// - host waits assert time after selecting
// - host may overlap waits of different modules
// - long reset pulse restores all settings
// - low-power pin level steers power mode
// - presence line held low while inserted
// - attention low on change, fault, status
// - attention is open collector, never high
// - host reads memory to find cause
// - attention released once set flags read
// - 256 bytes: lower 00h-7Fh, upper 80h-FFh
// - 128-byte pages mapped into upper half
// - lower always visible, one page above
// - bank selects instance of banked pages
// - lower memory and page 00h always present
// - pages 01h, 02h, bank 0 10h/11h present
// - bank 0 of 10h-1Fh covers lanes 1-8
//
// Implementation choices: the placing of the registers and the APB slave port.
module mgmt_module
  import mgmt_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // link pins
  mgmt_link_if.dev LINK,
  // module core side
  input wire logic I_FAULT,
  output logic O_LOW_POWER,
  output logic [7:0] O_PAGE,
  output logic [7:0] O_BANK,
  output logic O_FULL_RESET
);
  import mgmt_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_TX_NEXT} link_state_e;
  typedef enum logic [1:0] {K_ADDR, K_OFFS, K_DATA} rx_kind_e;

  logic [7:0] mem_r [0:MEM_BYTES-1];
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic scl_q_r;
  logic sda_q_r;
  logic scl_s;
  logic sda_s;
  logic selected;
  logic rst_pin_s;
  logic lp_s;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic [7:0] rst_cnt_r;
  logic full_rst;
  logic full_rst_q_r;
  logic [7:0] page_r;
  logic [7:0] bank_r;
  logic [7:0] ctrl_r;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] flags_set;
  logic [7:0] flags_clr;
  logic lp_q_r;
  logic low_power_r;
  logic attn_oe_n_r;
  link_state_e state_r;
  rx_kind_e kind_r;
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  logic rw_r;
  logic [7:0] ptr_r;
  logic sda_oe_n_r;
  logic [2:0] slot;
  logic [9:0] idx;
  logic [7:0] rd_byte;
  logic load_tx;
  logic write_byte;

  function automatic logic [2:0] page_slot(input logic [7:0] p, input logic [7:0] b);
    page_slot = 3'h0;
    if (p == PAGE_00) begin
      page_slot = 3'h1;
    end else if (p == PAGE_01) begin
      page_slot = 3'h2;
    end else if (p == PAGE_02) begin
      page_slot = 3'h3;
    end else if (b == 8'h00 && p == PAGE_10) begin
      page_slot = 3'h4;
    end else if (b == 8'h00 && p == PAGE_11) begin
      page_slot = 3'h5;
    end
  endfunction

  // pin synchronisers: scl, sda, select, reset, low power
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      s1_r <= 5'h1F;
      s2_r <= 5'h1F;
    end else begin
      s1_r <= {LINK.scl, LINK.sda, LINK.module_select_n, LINK.module_reset_n, LINK.low_power_request_pin};
      s2_r <= s1_r;
    end
  end

  assign scl_s = s2_r[4];
  assign sda_s = s2_r[3];
  assign selected = ~s2_r[2];
  assign rst_pin_s = s2_r[1];
  assign lp_s = s2_r[0];

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_det = scl_s & scl_q_r & ~sda_q_r & sda_s;
  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;

  // reset pin filter: only a pulse longer than the minimum gives a full reset
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rst_cnt_r <= 8'h00;
    end else if (rst_pin_s) begin
      rst_cnt_r <= 8'h00;
    end else if (rst_cnt_r != RESET_MIN_CNT) begin
      rst_cnt_r <= rst_cnt_r + 8'h01;
    end
  end

  assign full_rst = (rst_cnt_r == RESET_MIN_CNT);

  // page mapping and read path
  assign slot = page_slot(page_r, bank_r);
  assign idx = ptr_r[7] ? {slot - 3'h1, ptr_r[6:0]} + 10'(PAGE_BYTES) : {3'h0, ptr_r[6:0]};

  always_comb begin
    rd_byte = 8'h00;
    if (ptr_r[7]) begin
      if (slot != 3'h0) begin
        rd_byte = mem_r[idx];
      end
    end else if (ptr_r == STATUS_OFS) begin
      rd_byte = {7'h00, low_power_r};
    end else if (ptr_r == FLAGS_OFS) begin
      rd_byte = flags_r;
    end else if (ptr_r == CTRL_OFS) begin
      rd_byte = ctrl_r;
    end else if (ptr_r == BANK_OFS) begin
      rd_byte = bank_r;
    end else if (ptr_r == PAGE_OFS) begin
      rd_byte = page_r;
    end else begin
      rd_byte = mem_r[idx];
    end
  end

  assign load_tx = scl_fall & ((state_r == ST_RX_ACK && kind_r == K_ADDR && rw_r) || state_r == ST_TX_NEXT);
  assign write_byte = scl_fall & (state_r == ST_RX) & (cnt_r == 4'h8) & (kind_r == K_DATA);

  // two-wire slave
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_r <= ST_IDLE;
      kind_r <= K_ADDR;
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
      rw_r <= 1'b0;
      ptr_r <= 8'h00;
      sda_oe_n_r <= 1'b1;
    end else if (full_rst || !selected) begin
      state_r <= ST_IDLE;
      sda_oe_n_r <= 1'b1;
    end else if (start_det) begin
      state_r <= ST_RX;
      kind_r <= K_ADDR;
      cnt_r <= 4'h0;
      sda_oe_n_r <= 1'b1;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
      sda_oe_n_r <= 1'b1;
    end else if (load_tx) begin
      state_r <= ST_TX;
      sda_oe_n_r <= rd_byte[7];
      sh_r <= {rd_byte[6:0], 1'b0};
      cnt_r <= 4'h1;
      ptr_r <= ptr_r + 8'h01;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
        end
        ST_RX: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == 4'h8) begin
            cnt_r <= 4'h0;
            state_r <= ST_RX_ACK;
            sda_oe_n_r <= 1'b0;
            unique case (kind_r)
              K_ADDR: begin
                rw_r <= sh_r[0];
                if (sh_r[7:1] != DEV_ADDR) begin
                  state_r <= ST_IDLE;
                  sda_oe_n_r <= 1'b1;
                end
              end
              K_OFFS: ptr_r <= sh_r;
              K_DATA: ptr_r <= ptr_r + 8'h01;
              default: state_r <= ST_IDLE;
            endcase
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            state_r <= ST_RX;
            kind_r <= (kind_r == K_ADDR) ? K_OFFS : K_DATA;
            sda_oe_n_r <= 1'b1;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_r == 4'h8) begin
              state_r <= ST_TX_ACK;
              sda_oe_n_r <= 1'b1;
            end else begin
              sda_oe_n_r <= sh_r[7];
              sh_r <= {sh_r[6:0], 1'b0};
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            state_r <= sda_s ? ST_IDLE : ST_TX_NEXT;
          end
        end
        ST_TX_NEXT: begin
        end
      endcase
    end
  end

  // memory storage, outside the reset domain of the settings
  always_ff @(posedge I_CLK) begin
    if (write_byte && (ptr_r[7] ? slot != 3'h0 : ptr_r < BANK_OFS && ptr_r != STATUS_OFS &&
        ptr_r != FLAGS_OFS && ptr_r != CTRL_OFS)) begin
      mem_r[idx] <= sh_r;
    end
  end

  // user settings: page, bank, control, all restored by a full reset
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      page_r <= PAGE_RST;
      bank_r <= BANK_RST;
      ctrl_r <= CTRL_RST;
    end else if (full_rst) begin
      page_r <= PAGE_RST;
      bank_r <= BANK_RST;
      ctrl_r <= CTRL_RST;
    end else if (write_byte) begin
      if (ptr_r == PAGE_OFS) begin
        page_r <= sh_r;
      end
      if (ptr_r == BANK_OFS) begin
        bank_r <= sh_r;
      end
      if (ptr_r == CTRL_OFS) begin
        ctrl_r <= sh_r;
      end
    end
  end

  // power mode from pin level and forced control bit
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      low_power_r <= 1'b1;
      lp_q_r <= 1'b1;
      full_rst_q_r <= 1'b0;
    end else begin
      low_power_r <= lp_s | ctrl_r[CTRL_FORCE_LP];
      lp_q_r <= lp_s;
      full_rst_q_r <= full_rst;
    end
  end

  // latched flags; a set in the clearing cycle survives
  always_comb begin
    flags_set = 8'h00;
    flags_set[FLG_LP_CHG] = lp_s ^ lp_q_r;
    flags_set[FLG_RESET_DONE] = full_rst_q_r & ~full_rst;
    flags_set[FLG_FAULT] = I_FAULT;
    flags_set[FLG_BAD_PAGE] = write_byte & (ptr_r == PAGE_OFS || ptr_r == BANK_OFS) &
      (page_slot(ptr_r == PAGE_OFS ? sh_r : page_r, ptr_r == BANK_OFS ? sh_r : bank_r) == 3'h0);
    flags_clr = (load_tx && ptr_r == FLAGS_OFS) ? flags_r : 8'h00;
    flags_nxt = (flags_r & ~flags_clr) | flags_set;
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      flags_r <= 8'h00;
      attn_oe_n_r <= 1'b1;
    end else if (full_rst) begin
      flags_r <= 8'h00;
      attn_oe_n_r <= 1'b1;
    end else begin
      flags_r <= flags_nxt;
      attn_oe_n_r <= ~|flags_nxt;
    end
  end

  assign LINK.sda_d_o = 1'b0;
  assign LINK.sda_d_oe_n = sda_oe_n_r;
  assign LINK.attn_o = 1'b0;
  assign LINK.attn_oe_n = attn_oe_n_r;
  assign LINK.present_o = 1'b0;
  assign LINK.present_oe_n = 1'b0;
  assign O_LOW_POWER = low_power_r;
  assign O_PAGE = page_r;
  assign O_BANK = bank_r;
  assign O_FULL_RESET = full_rst;
endmodule // mgmt_module

/* File: hw/mgmt_host.sv */
// host end: APB registers, sideband pin control, two-wire master for single-byte transfers
// assumes one module on the link; SCL is made here from I_CLK
module mgmt_host
  import mgmt_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // link pins
  mgmt_link_if.host LINK
);
  import mgmt_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_SYM} host_state_e;

  logic [2:0] pins_r;
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic wr_acc;
  logic mapped;
  logic [7:0] off_r;
  logic [7:0] dat_r;
  logic rd_r;
  logic err_r;
  logic [7:0] rdata_r;
  logic [7:0] sel_tmr_r;
  host_state_e state_r;
  logic [2:0] div_r;
  logic tick;
  logic [1:0] q_r;
  logic [2:0] seg_r;
  logic [3:0] bit_r;
  logic [8:0] tx_sh_r;
  logic [8:0] rx_sh_r;
  logic scl_r;
  logic sda_oe_n_r;
  logic seg_start;
  logic seg_stop;
  logic [7:0] seg_byte;

  assign mapped = (I_PADDR == A_PINS) || (I_PADDR == A_CMD) || (I_PADDR == A_STAT);
  assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE & pready_r;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      s1_r <= 3'h7;
      s2_r <= 3'h7;
    end else begin
      s1_r <= {LINK.sda, LINK.attention_n, LINK.module_present_n};
      s2_r <= s1_r;
    end
  end

  // APB: one wait-free access cycle after setup
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= I_PSEL & ~I_PENABLE;
      pslverr_r <= I_PSEL & ~I_PENABLE & ~mapped;
      if (I_PSEL && !I_PENABLE) begin
        prdata_r <= 32'h0000_0000;
        if (I_PADDR == A_PINS) begin
          prdata_r <= {29'h0, pins_r};
        end else if (I_PADDR == A_STAT) begin
          prdata_r <= {16'h0, rdata_r, 4'h0, ~s2_r[0], ~s2_r[1], err_r, state_r != H_IDLE};
        end
      end
    end
  end

  // select timer restarts on each change of the select line
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pins_r <= PINS_RST;
      sel_tmr_r <= 8'h00;
    end else if (wr_acc && I_PADDR == A_PINS) begin
      pins_r <= I_PWDATA[2:0];
      if (I_PWDATA[PIN_SEL] != pins_r[PIN_SEL]) begin
        sel_tmr_r <= I_PWDATA[PIN_SEL] ? SEL_ASSERT_CNT : SEL_DEASSERT_CNT;
      end
    end else if (sel_tmr_r != 8'h00) begin
      sel_tmr_r <= sel_tmr_r - 8'h01;
    end
  end

  // quarter-bit divider
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      div_r <= 3'h0;
    end else begin
      div_r <= (tick || state_r != H_SYM) ? 3'h0 : div_r + 3'h1;
    end
  end

  assign tick = (state_r == H_SYM) && (div_r == SCL_QUARTER_CNT);
  assign seg_start = (seg_r == 3'h0) || (rd_r && seg_r == 3'h4);
  assign seg_stop = rd_r ? (seg_r == 3'h3 || seg_r == 3'h7) : (seg_r == 3'h4);

  always_comb begin
    unique case (seg_r)
      3'h1: seg_byte = {DEV_ADDR, 1'b0};
      3'h2: seg_byte = off_r;
      3'h5: seg_byte = {DEV_ADDR, 1'b1};
      3'h3: seg_byte = dat_r;
      default: seg_byte = 8'hFF;
    endcase
  end

  // two-wire master sequencer
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_r <= H_IDLE;
      off_r <= 8'h00;
      dat_r <= 8'h00;
      rd_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= 8'h00;
      q_r <= 2'h0;
      seg_r <= 3'h0;
      bit_r <= 4'h0;
      tx_sh_r <= 9'h1FF;
      rx_sh_r <= 9'h000;
      scl_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
    end else begin
      unique case (state_r)
        H_IDLE: begin
          if (wr_acc && I_PADDR == A_CMD) begin
            off_r <= I_PWDATA[7:0];
            dat_r <= I_PWDATA[15:8];
            rd_r <= I_PWDATA[CMD_READ];
            err_r <= 1'b0;
            seg_r <= 3'h0;
            q_r <= 2'h0;
            state_r <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (sel_tmr_r == 8'h00) begin
            state_r <= H_SYM;
          end
        end
        H_SYM: begin
          if (tick) begin
            q_r <= q_r + 2'h1;
            if (seg_start) begin
              scl_r <= (q_r == 2'h1 || q_r == 2'h2);
              sda_oe_n_r <= (q_r < 2'h2);
            end else if (seg_stop) begin
              scl_r <= (q_r != 2'h0);
              sda_oe_n_r <= (q_r >= 2'h2);
            end else begin
              scl_r <= (q_r == 2'h1 || q_r == 2'h2);
              if (q_r == 2'h0) begin
                sda_oe_n_r <= (bit_r == 4'h0) ? seg_byte[7] : tx_sh_r[8];
                if (bit_r == 4'h0) begin
                  tx_sh_r <= {seg_byte, 1'b1};
                end
              end
              if (q_r == 2'h2) begin
                rx_sh_r <= {rx_sh_r[7:0], s2_r[2]};
              end
            end
            if (q_r == 2'h3) begin
              if (!seg_start && !seg_stop) begin
                tx_sh_r <= {tx_sh_r[7:0], 1'b1};
                bit_r <= bit_r + 4'h1;
              end
              if (seg_stop) begin
                state_r <= (err_r || seg_r == 3'h7 || (!rd_r && seg_r == 3'h4)) ? H_IDLE : H_SYM;
                seg_r <= seg_r + 3'h1;
              end else if (seg_start) begin
                seg_r <= seg_r + 3'h1;
              end else if (bit_r == 4'h8) begin
                bit_r <= 4'h0;
                if (seg_r == 3'h6) begin
                  rdata_r <= rx_sh_r[8:1];
                  seg_r <= 3'h7;
                end else if (rx_sh_r[0]) begin
                  err_r <= 1'b1;
                  seg_r <= (rd_r && seg_r > 3'h3) ? 3'h7 : (rd_r ? 3'h3 : 3'h4);
                end else begin
                  seg_r <= seg_r + 3'h1;
                end
              end
            end
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign O_PRDATA = prdata_r;
  assign O_PREADY = pready_r;
  assign O_PSLVERR = pslverr_r;
  assign LINK.scl = scl_r;
  assign LINK.sda_h_o = 1'b0;
  assign LINK.sda_h_oe_n = sda_oe_n_r;
  assign LINK.module_select_n = ~pins_r[PIN_SEL];
  assign LINK.module_reset_n = ~pins_r[PIN_RESET];
  assign LINK.low_power_request_pin = pins_r[PIN_LP];
endmodule // mgmt_host

/* File: verif/mgmt_link_chk.sv */
// assertions on the link pins between host end and module end
// assumes instantiation beside the link interface, one clock domain
module mgmt_link_chk
  import mgmt_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // link signals
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_d_o,
  input wire logic sda_d_oe_n,
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic low_power_request_pin,
  input wire logic module_present_n,
  input wire logic attn_o,
  input wire logic attn_oe_n
);
  logic sel_q_r;
  logic [7:0] sel_cnt_r;
  logic [7:0] rst_cnt_r;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // cycles since the last select change
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sel_q_r <= 1'b1;
      sel_cnt_r <= 8'hFF;
    end else begin
      sel_q_r <= module_select_n;
      if (module_select_n != sel_q_r) begin
        sel_cnt_r <= 8'h00;
      end else if (sel_cnt_r != 8'hFF) begin
        sel_cnt_r <= sel_cnt_r + 8'h01;
      end
    end
  end
  // consecutive cycles of reset pin low
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rst_cnt_r <= 8'h00;
    end else if (module_reset_n) begin
      rst_cnt_r <= 8'h00;
    end else if (rst_cnt_r != 8'hFF) begin
      rst_cnt_r <= rst_cnt_r + 8'h01;
    end
  end
  sequence long_rst_end;
    $rose(module_reset_n) && rst_cnt_r >= RESET_MIN_CNT + 8'h0A;
  endsequence
  sequence attn_soon;
    ##[1:12] !attn_oe_n;
  endsequence
  a_start_after_sel: assert property (scl && $past(scl) && $fell(sda) |-> sel_cnt_r >= SEL_ASSERT_CNT)
    else $error("start too soon after select change");
  a_drive_only_sel: assert property (!sda_d_oe_n |-> !module_select_n)
    else $error("module drives sda while deselected");
  a_present_low: assert property (module_present_n == 1'b0)
    else $error("presence line not low");
  a_pull_low_only: assert property (attn_o == 1'b0 && sda_d_o == 1'b0)
    else $error("open drain line driven high");
  a_reset_quiet: assert property (rst_cnt_r >= RESET_MIN_CNT + 8'h0A |-> sda_d_oe_n && attn_oe_n)
    else $error("module active during long reset");
  a_reset_done_attn: assert property (long_rst_end |-> attn_soon)
    else $error("no attention after full reset");
  a_lp_change_attn: assert property ($changed(low_power_request_pin) && module_reset_n |-> attn_soon)
    else $error("no attention after low power pin change");
  a_attn_release: assert property ($rose(attn_oe_n) |-> !module_select_n || rst_cnt_r != 8'h00)
    else $error("attention released without a read");
endmodule // mgmt_link_chk

/* File: verif/tb_top.sv */
// testbench: host end and module end joined by the link, driven over APB
// assumes design files and checker compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mgmt_pkg::*;
  typedef struct packed {logic rd; logic [7:0] ofs; logic [7:0] wd; logic [7:0] ex;} row_s;
  // rd, offset, write data, expected read byte
  localparam logic [24:0] ROWS [23] = '{
    25'h0_10_3C_00, 25'h1_10_00_3C, 25'h0_7F_01_00, 25'h0_80_A5_00, 25'h1_80_00_A5, 25'h0_7F_02_00,
    25'h0_80_5A_00, 25'h1_80_00_5A, 25'h0_7F_01_00, 25'h1_80_00_A5, 25'h1_10_00_3C, 25'h0_7F_10_00,
    25'h0_FF_77_00, 25'h1_FF_00_77, 25'h0_7E_01_00, 25'h1_FF_00_00, 25'h0_7E_00_00, 25'h1_FF_00_77,
    25'h0_7F_00_00, 25'h0_90_11_00, 25'h1_90_00_11, 25'h0_03_FE_00, 25'h1_03_00_01};
  logic clk, rst, psel, penable, pwrite, pready, pslverr, slverr, fault, low_power, full_reset;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d, stat;
  logic [7:0] page, bank;
  row_s r;
  int err_total = 0;
  int cmp_count = 0;
  mgmt_link_if link ();
  mgmt_module mgmt_module_i (.I_CLK(clk), .I_RST(rst), .LINK(link.dev), .I_FAULT(fault),
    .O_LOW_POWER(low_power), .O_PAGE(page), .O_BANK(bank), .O_FULL_RESET(full_reset));
  mgmt_host mgmt_host_i (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .LINK(link.host));
  mgmt_link_chk mgmt_link_chk_i (.I_CLK(clk), .I_RST(rst), .scl(link.scl), .sda(link.sda),
    .sda_d_o(link.sda_d_o), .sda_d_oe_n(link.sda_d_oe_n), .module_select_n(link.module_select_n),
    .module_reset_n(link.module_reset_n), .low_power_request_pin(link.low_power_request_pin),
    .module_present_n(link.module_present_n), .attn_o(link.attn_o), .attn_oe_n(link.attn_oe_n));
  task automatic summarize();
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] ex);
    cmp_count++;
    if (seen !== ex) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, ex);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      summarize();
    end
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // one two-wire byte transfer, leaves the final status in stat
  task automatic mem(input logic rd, input logic [7:0] ofs, input logic [7:0] wd);
    int n;
    apb(1'b1, A_CMD, {15'h0000, rd, wd, ofs}, stat);
    n = 0;
    do begin
      apb(1'b0, A_STAT, 32'h0, stat);
      n++;
    end while (stat[ST_BUSY] !== 1'b0 && n < 3000);
    if (stat[ST_BUSY] !== 1'b0) begin
      err_total++;
      summarize();
    end
  endtask
  task automatic flags(input logic [7:0] ex);
    repeat (8) @(posedge clk);
    apb(1'b0, A_STAT, 32'h0, d);
    check(d[ST_ATTN], 1'b1);
    mem(1'b1, FLAGS_OFS, 8'h00);
    check(stat[15:8], ex);
    check(stat[ST_ATTN], 1'b0);
  endtask
  task automatic pulse(input int n, input logic ex);
    apb(1'b1, A_PINS, 32'h3, d);
    repeat (n) @(posedge clk);
    check(full_reset, ex);
    apb(1'b1, A_PINS, 32'h1, d);
    repeat (10) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (95000) @(posedge clk);
    err_total++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fault = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, A_PINS, 32'h0, d);
    check(d, 32'h4);
    check(slverr, 1'b0);
    check({low_power, bank, page, full_reset}, 32'h20000);
    apb(1'b0, A_STAT, 32'h0, d);
    check(d[ST_PRESENT], 1'b1);
    check(d[ST_ATTN], 1'b0);
    // unmapped host register: error response, reads zero
    apb(1'b0, 12'h00C, 32'h0, d);
    check(slverr, 1'b1);
    check(d, 32'h0);
    apb(1'b1, A_PINS, 32'h5, d);
    for (int i = 0; i < 23; i++) begin
      r = ROWS[i];
      mem(r.rd, r.ofs, r.wd);
      check(stat[ST_NACK], 1'b0);
      if (r.rd) begin
        check(stat[15:8], r.ex);
      end
    end
    // a write to the flags byte must not clear them
    mem(1'b0, FLAGS_OFS, 8'h00);
    flags(8'h02);
    fault <= 1'b1;
    @(posedge clk);
    fault <= 1'b0;
    flags(8'h08);
    apb(1'b1, A_PINS, 32'h1, d);
    repeat (8) @(posedge clk);
    check(low_power, 1'b0);
    flags(8'h01);
    mem(1'b1, STATUS_OFS, 8'h00);
    check(stat[15:8], 8'h00);
    mem(1'b0, CTRL_OFS, 8'h01);
    check(low_power, 1'b1);
    apb(1'b1, A_PINS, 32'h0, d);
    mem(1'b1, 8'h10, 8'h00);
    check(stat[ST_NACK], 1'b1);
    apb(1'b1, A_PINS, 32'h1, d);
    mem(1'b0, PAGE_OFS, PAGE_02);
    pulse(50, 1'b0);
    check(page, PAGE_02);
    pulse(120, 1'b1);
    check({page, low_power}, 9'h000);
    flags(8'h04);
    summarize();
  end
endmodule // tb_top
